// ---- hdl/scp_card_pins.sv ----
// Card-side pin logic: auxiliary lines, card clock, reset, serial data and presence.
//
// Functional notes
// - Second aux line is identification bit 1.
// - First aux line is identification bit 0.
// - Second aux line driven open-drain only.
// - Async input reads: grounded zero, else one.
// - Sync mode reads return last forced level.
// - Card clock comes from clock selector.
// - Card clock low during startup or no supply.
// - Host picks clock slope; device applies it.
// - Presence input pulled high, active low default.
// - Presence input filtered against short spikes.
// - Host sets presence polarity; device obeys.
// - Normal mode: status high when card inserted.
// - Special mode: status mirrors filtered input level.
// - Host reset level translated to card reset.
// - Card reset follows host only while selected.
// - Card reset grounded whenever card deactivated.
// - Serial line translated in both directions.
// - Serial line low during startup or no supply.
`timescale 1ns/10ps
`default_nettype none
module scp_card_pins (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire scp_pkg::scp_supply_s supply,
  input wire scp_pkg::scp_cfg_s cfg,
  input wire logic cs_n,
  input wire logic clk_select_in,
  input wire logic host_reset_req,
  input wire logic aux_write_valid,
  input wire logic [1:0] aux_write_data,
  input wire logic aux_line_id_bit0_in,
  output logic aux_line_id_bit0_out,
  output logic aux_line_id_bit0_oe_n,
  input wire logic aux_line_id_bit1_in,
  output logic aux_line_id_bit1_out,
  output logic aux_line_id_bit1_oe_n,
  output logic [1:0] cs_id_value,
  output logic card_clock_out,
  output logic card_clock_slope_fast,
  output logic card_reset_out,
  input wire logic host_io_in,
  output logic host_io_out,
  output logic host_io_oe_n,
  input wire logic card_serial_line_in,
  output logic card_serial_line_out,
  output logic card_serial_line_oe_n,
  input wire logic card_presence_input,
  output logic card_present,
  output logic presence_status_bit
);

  // Reads an auxiliary line: in sync mode the pin is not trusted as data.
  function automatic logic aux_level(input logic sync, input logic forced, input logic pin);
    aux_level = sync ? forced : pin;
  endfunction : aux_level

  // Presence as the host's polarity setting interprets the filtered pin.
  function automatic logic presence_level(input logic active_high, input logic level);
    presence_level = active_high ? level : !level;
  endfunction : presence_level

  logic supply_ready;
  logic [1:0] aux_force_q;
  logic [1:0] cs_id_q;
  logic card_clock_q;
  logic slope_fast_q;
  logic card_reset_q;
  scp_pkg::scp_io_state_e io_state_q;
  scp_pkg::scp_io_state_e io_state_d;
  logic host_oe_n_q;
  logic card_oe_n_q;
  logic det_filt;
  logic present_q;
  logic status_q;

  // Card pins are only live with the supply up and its startup finished.
  assign supply_ready = supply.on && !supply.starting;

  // ---------------------------------------------------------------------
  // Auxiliary lines.
  // ---------------------------------------------------------------------

  // The forced level is what a write to the card last asked for; released
  // (one) after reset so the external pull-up sets the idle level.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_force_q <= scp_pkg::AUX_FORCE_RST;
    end else if (aux_write_valid) begin
      aux_force_q <= aux_write_data;
    end
  end

  // Open-drain only: the output value is always zero and a one is made by
  // letting go, so no push-pull fight with the card is possible.
  assign aux_line_id_bit1_out = 1'b0;
  assign aux_line_id_bit0_out = 1'b0;
  assign aux_line_id_bit1_oe_n = !supply_ready || aux_force_q[scp_pkg::ID_BIT1_POS];
  assign aux_line_id_bit0_oe_n = !supply_ready || aux_force_q[scp_pkg::ID_BIT0_POS];

  // The pin is read in positive logic; a floating pin reads one because
  // the pull-up lifts it, so no inversion is applied here.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_id_q <= scp_pkg::AUX_FORCE_RST;
    end else begin
      cs_id_q[scp_pkg::ID_BIT1_POS] <= aux_level(cfg.sync_mode,
        aux_force_q[scp_pkg::ID_BIT1_POS], aux_line_id_bit1_in);
      cs_id_q[scp_pkg::ID_BIT0_POS] <= aux_level(cfg.sync_mode,
        aux_force_q[scp_pkg::ID_BIT0_POS], aux_line_id_bit0_in);
    end
  end

  assign cs_id_value = cs_id_q;

  // ---------------------------------------------------------------------
  // Card clock.
  // ---------------------------------------------------------------------

  // The selector output is retimed by one flop; this adds one cycle of
  // delay but keeps the pin free of gating glitches.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      card_clock_q <= 1'b0;
    end else if (!supply_ready) begin
      card_clock_q <= 1'b0;
    end else begin
      card_clock_q <= clk_select_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slope_fast_q <= scp_pkg::SLOPE_FAST_RST;
    end else begin
      slope_fast_q <= cfg.slope_fast;
    end
  end

  assign card_clock_out = card_clock_q;
  assign card_clock_slope_fast = slope_fast_q;

  // ---------------------------------------------------------------------
  // Card reset.
  // ---------------------------------------------------------------------

  // With chip select high the last passed level is held, so several
  // couplers can share one host reset line.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      card_reset_q <= scp_pkg::CARD_RST_RST;
    end else if (!supply.active || !supply_ready) begin
      card_reset_q <= 1'b0;
    end else if (!cs_n) begin
      card_reset_q <= host_reset_req;
    end
  end

  assign card_reset_out = card_reset_q;

  // ---------------------------------------------------------------------
  // Serial data translator.
  // ---------------------------------------------------------------------

  // Whichever side pulls low first owns the line until it lets go. The
  // release state waits for both wires to read high again; otherwise our
  // own slowly released drive would be seen as the far side talking.
  always_comb begin
    io_state_d = io_state_q;
    case (io_state_q)
      scp_pkg::IO_IDLE: begin
        if (!host_io_in) begin
          io_state_d = scp_pkg::IO_HOST;
        end else if (!card_serial_line_in) begin
          io_state_d = scp_pkg::IO_CARD;
        end
      end
      scp_pkg::IO_HOST: begin
        if (host_io_in) begin
          io_state_d = scp_pkg::IO_REL;
        end
      end
      scp_pkg::IO_CARD: begin
        if (card_serial_line_in) begin
          io_state_d = scp_pkg::IO_REL;
        end
      end
      scp_pkg::IO_REL: begin
        if (host_io_in && card_serial_line_in) begin
          io_state_d = scp_pkg::IO_IDLE;
        end
      end
      default: begin
        io_state_d = scp_pkg::IO_IDLE;
      end
    endcase
    if (!supply_ready) begin
      io_state_d = scp_pkg::IO_REL;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_state_q <= scp_pkg::IO_REL;
    end else begin
      io_state_q <= io_state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      card_oe_n_q <= 1'b0;
      host_oe_n_q <= 1'b1;
    end else if (!supply_ready) begin
      card_oe_n_q <= 1'b0;
      host_oe_n_q <= 1'b1;
    end else begin
      card_oe_n_q <= !(io_state_d == scp_pkg::IO_HOST);
      host_oe_n_q <= !(io_state_d == scp_pkg::IO_CARD);
    end
  end

  assign card_serial_line_out = 1'b0;
  assign card_serial_line_oe_n = card_oe_n_q;
  assign host_io_out = 1'b0;
  assign host_io_oe_n = host_oe_n_q;

  // ---------------------------------------------------------------------
  // Card presence.
  // ---------------------------------------------------------------------

  // The weak pull-up is outside; an open switch therefore reads high,
  // which is why the filter and the default polarity start at high/low.
  scp_glitch_filter u_det_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .raw_in(card_presence_input),
    .filt_out(det_filt)
  );

  // The host must program the polarity to suit the fitted switch; a
  // wrong setting simply inverts the presence answer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      present_q <= 1'b0;
    end else begin
      present_q <= presence_level(cfg.det_active_high, det_filt);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 1'b0;
    end else if (cfg.special_mode) begin
      status_q <= det_filt;
    end else begin
      status_q <= presence_level(cfg.det_active_high, det_filt);
    end
  end

  assign card_present = present_q;
  assign presence_status_bit = status_q;

  // ---------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_aux1_opendrain: assert property (
    !aux_line_id_bit1_oe_n |-> !aux_line_id_bit1_out && supply_ready
      && !aux_force_q[scp_pkg::ID_BIT1_POS])
    else $error("Second aux line driven other than low.");

  a_id_bit1_async: assert property (
    !cfg.sync_mode ##1 !$past(cfg.sync_mode)
      |-> cs_id_value[1] == $past(aux_line_id_bit1_in))
    else $error("Id bit 1 does not follow second aux line.");

  a_id_bit0_sync: assert property (
    cfg.sync_mode |=> cs_id_value[0] == $past(aux_force_q[0]))
    else $error("Sync read of id bit 0 is not the forced level.");

  a_clock_held_low: assert property (
    !supply.on || supply.starting |=> !card_clock_out)
    else $error("Card clock not low without a ready supply.");

  a_clock_follows: assert property (
    supply_ready |=> card_clock_out == $past(clk_select_in))
    else $error("Card clock does not follow clock selector.");

  a_reset_grounded: assert property (
    !supply.active ##1 !supply.active |-> !card_reset_out)
    else $error("Card reset not grounded while deactivated.");

  a_reset_held_cs: assert property (
    cs_n && supply.active && supply_ready |=> $stable(card_reset_out))
    else $error("Card reset changed with chip select high.");

  a_io_low_startup: assert property (
    supply.starting |=> !card_serial_line_oe_n && !card_serial_line_out)
    else $error("Serial line not held low during startup.");

  a_io_host_to_card: assert property (
    io_state_q == scp_pkg::IO_IDLE && !host_io_in && supply_ready
      ##1 supply_ready |-> !card_serial_line_oe_n)
    else $error("Host low not passed to card.");

  a_no_dual_drive: assert property (
    !(!host_io_oe_n && !card_oe_n_q && supply_ready))
    else $error("Translator drives both sides at once.");

  a_status_normal: assert property (
    !cfg.special_mode ##1 !cfg.special_mode |-> presence_status_bit == present_q)
    else $error("Normal-mode status differs from presence.");

  a_status_special: assert property (
    cfg.special_mode |=> presence_status_bit == $past(det_filt))
    else $error("Special-mode status is not the input level.");

  a_filter_spike: assert property (
    $changed(det_filt) |-> $past(card_presence_input, 2) == det_filt)
    else $error("Filter output moved on a spike.");

  a_slope_applied: assert property (
    ##1 card_clock_slope_fast == $past(cfg.slope_fast))
    else $error("Clock slope setting not applied.");

  a_aux_async_read: assert property (
    !cfg.sync_mode |=> cs_id_value[scp_pkg::ID_BIT0_POS] == $past(aux_line_id_bit0_in))
    else $error("Id bit 0 does not follow first aux line.");

  a_present_polarity: assert property (
    ##1 card_present == ($past(cfg.det_active_high) == $past(det_filt)))
    else $error("Presence does not follow the polarity setting.");

  a_reset_follows: assert property (
    !cs_n && supply.active && supply_ready |=> card_reset_out == $past(host_reset_req))
    else $error("Card reset does not follow host request.");

  a_card_to_host: assert property (
    io_state_q == scp_pkg::IO_IDLE && host_io_in && !card_serial_line_in
      && supply_ready |=> !host_io_oe_n)
    else $error("Card low not passed to host.");

  c_card_inserted: cover property (!present_q ##1 present_q);
  c_host_drives: cover property (io_state_q == scp_pkg::IO_HOST);
  c_card_drives: cover property (io_state_q == scp_pkg::IO_CARD ##1 io_state_q == scp_pkg::IO_REL);
  c_reset_passed: cover property (!cs_n && host_reset_req ##1 card_reset_out);
  c_special_mode: cover property (cfg.special_mode && presence_status_bit);

endmodule : scp_card_pins
`default_nettype wire

// ---- hdl/scp_glitch_filter.sv ----
// Spike filter for the card presence input.
`timescale 1ns/10ps
`default_nettype none
module scp_glitch_filter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic raw_in,
  output logic filt_out
);

  logic [scp_pkg::FILTER_CNT_W-1:0] cnt_q;
  logic filt_q;

  // The counter restarts whenever input and output agree, so any spike shorter
  // than the filter interval leaves the output untouched.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (raw_in == filt_q || cnt_q == scp_pkg::FILTER_LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= scp_pkg::DET_FILT_RST;
    end else if (raw_in != filt_q && cnt_q == scp_pkg::FILTER_LAST) begin
      filt_q <= raw_in;
    end
  end

  assign filt_out = filt_q;

endmodule : scp_glitch_filter
`default_nettype wire

// ---- hdl/scp_pkg.sv ----
// Shared constants and carrier types for the smart card pin-side control block.
package scp_pkg;

  // System clock rate, used to turn times into cycle counts.
  localparam int CLK_FREQ_MHZ = 200;

  // Presence filter: a level must persist this long before it is believed.
  localparam int FILTER_TIME_NS = 5000;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int FILTER_CNT_W = 10;
  localparam logic [FILTER_CNT_W-1:0] FILTER_LAST = FILTER_CNT_W'(FILTER_CYCLES - 1);

  // Positions of the auxiliary lines in the chip-select identification value.
  localparam int ID_BIT0_POS = 0;
  localparam int ID_BIT1_POS = 1;

  // Reset values.
  localparam logic [1:0] AUX_FORCE_RST = 2'h3;
  localparam logic DET_FILT_RST = 1'h1;
  localparam logic CARD_RST_RST = 1'h0;
  localparam logic SLOPE_FAST_RST = 1'h0;

  // Direction state of the serial line translator.
  typedef enum logic [3:0] {
    IO_IDLE = 4'h1,
    IO_HOST = 4'h2,
    IO_CARD = 4'h4,
    IO_REL  = 4'h8
  } scp_io_state_e;

  // Card supply and activation status, from the supply sequencer.
  typedef struct packed {
    logic on;
    logic starting;
    logic active;
  } scp_supply_s;

  // Settings programmed by the host through its serial command.
  typedef struct packed {
    logic slope_fast;
    logic det_active_high;
    logic special_mode;
    logic sync_mode;
  } scp_cfg_s;

endpackage : scp_pkg

// ---- tb/scp_card_model.sv ----
// Card and connector model: pull-ups, grounded aux pins, card data and presence switch.
`timescale 1ns/10ps
`default_nettype none
module scp_card_model (
  input wire logic aux0_oe_n,
  input wire logic aux1_oe_n,
  input wire logic io_oe_n,
  input wire logic gnd0,
  input wire logic gnd1,
  input wire logic io_low,
  input wire logic sw_closed,
  output logic aux0_lvl,
  output logic aux1_lvl,
  output logic io_lvl,
  output logic det_lvl
);
  // Open-drain lines with pull-up to the card supply: low if any party pulls low.
  assign aux0_lvl = !(!aux0_oe_n || gnd0);
  assign aux1_lvl = !(!aux1_oe_n || gnd1);
  assign io_lvl = !(!io_oe_n || io_low);
  // The presence pin rests high through its weak pull-up while the switch is open.
  assign det_lvl = !sw_closed;
endmodule : scp_card_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the card pin logic.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  scp_pkg::scp_supply_s supply = '0;
  scp_pkg::scp_cfg_s cfg = '0;
  logic cs_n = 1'h1, sel = 1'h0, req = 1'h0, wv = 1'h0;
  logic [1:0] wd = 2'h3;
  logic gnd0 = 1'h0, gnd1 = 1'h0, io_low = 1'h0, sw = 1'h0, host_low = 1'h0;
  logic a0, a1, a0_out, a1_out, a0_oe_n, a1_oe_n, clk_out, slope, rst_out;
  logic h_out, h_oe_n, io_out, io_oe_n, io_lvl, det, present, status;
  logic [1:0] id;
  int n_errors = 0;
  int check_count = 0;
  wire logic host_lvl = !(host_low || !h_oe_n);

  always #2.5 clk_sys = !clk_sys;

  scp_card_model card (.aux0_oe_n(a0_oe_n), .aux1_oe_n(a1_oe_n), .io_oe_n(io_oe_n),
    .gnd0(gnd0), .gnd1(gnd1), .io_low(io_low), .sw_closed(sw), .aux0_lvl(a0),
    .aux1_lvl(a1), .io_lvl(io_lvl), .det_lvl(det));

  scp_card_pins dut (.clk_sys(clk_sys), .rst_n(rst_n), .supply(supply), .cfg(cfg),
    .cs_n(cs_n), .clk_select_in(sel), .host_reset_req(req), .aux_write_valid(wv),
    .aux_write_data(wd), .aux_line_id_bit0_in(a0), .aux_line_id_bit0_out(a0_out),
    .aux_line_id_bit0_oe_n(a0_oe_n), .aux_line_id_bit1_in(a1),
    .aux_line_id_bit1_out(a1_out), .aux_line_id_bit1_oe_n(a1_oe_n), .cs_id_value(id),
    .card_clock_out(clk_out), .card_clock_slope_fast(slope), .card_reset_out(rst_out),
    .host_io_in(host_lvl), .host_io_out(h_out), .host_io_oe_n(h_oe_n),
    .card_serial_line_in(io_lvl), .card_serial_line_out(io_out),
    .card_serial_line_oe_n(io_oe_n), .card_presence_input(det), .card_present(present),
    .presence_status_bit(status));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done;
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic aux_write(input logic [1:0] d);
    wv = 1'h1;
    wd = d;
    cyc(1);
    wv = 1'h0;
  endtask : aux_write

  task automatic t_aux;
    gnd1 = 1'h1;
    cyc(3);
    chk("id async bit1 grounded", 2'h1, id);
    chk("aux1 out level", 2'h0, a1_out);
    chk("aux0 out level", 2'h0, a0_out);
    gnd1 = 1'h0;
    gnd0 = 1'h1;
    cyc(3);
    chk("id async bit0 grounded", 2'h2, id);
    gnd0 = 1'h0;
    cyc(3);
    chk("id async open", 2'h3, id);
    cfg.sync_mode = 1'h1;
    aux_write(2'h2);
    gnd1 = 1'h1;
    cyc(3);
    chk("aux0 pulled", 2'h0, a0_oe_n);
    chk("aux1 released", 2'h1, a1_oe_n);
    chk("id sync forced", 2'h2, id);
    aux_write(2'h3);
    gnd1 = 1'h0;
    cfg.sync_mode = 1'h0;
    cyc(3);
    chk("aux both released", 2'h3, {a1_oe_n, a0_oe_n});
  endtask : t_aux

  task automatic t_clock;
    for (int i = 0; i < 4; i++) begin
      sel = i[0] ^ 1'h1;
      cyc(2);
      chk("card clock follows", sel, clk_out);
    end
    cfg.slope_fast = 1'h1;
    cyc(2);
    chk("slope fast", 2'h1, slope);
    cfg.slope_fast = 1'h0;
    cyc(2);
    chk("slope slow", 2'h0, slope);
    sel = 1'h1;
    supply.starting = 1'h1;
    host_low = 1'h1;
    cyc(3);
    chk("clock in startup", 2'h0, clk_out);
    chk("io in startup", 2'h0, io_oe_n);
    chk("host io in startup", 2'h1, h_oe_n);
    supply.starting = 1'h0;
    supply.on = 1'h0;
    cyc(3);
    chk("clock no supply", 2'h0, clk_out);
    chk("io no supply", 2'h0, io_oe_n);
    host_low = 1'h0;
    supply.on = 1'h1;
    cyc(5);
  endtask : t_clock

  task automatic t_reset;
    cs_n = 1'h0;
    req = 1'h1;
    cyc(2);
    chk("card reset follows", 2'h1, rst_out);
    cs_n = 1'h1;
    req = 1'h0;
    cyc(3);
    chk("card reset unselected", 2'h1, rst_out);
    cs_n = 1'h0;
    cyc(2);
    chk("card reset low", 2'h0, rst_out);
    req = 1'h1;
    cyc(2);
    supply.active = 1'h0;
    cyc(2);
    chk("card reset deactivated", 2'h0, rst_out);
    supply.active = 1'h1;
    cs_n = 1'h1;
  endtask : t_reset

  task automatic t_io;
    host_low = 1'h1;
    cyc(2);
    chk("host to card low", 2'h0, io_lvl);
    chk("card io out level", 2'h0, io_out);
    host_low = 1'h0;
    cyc(4);
    chk("host to card release", 2'h1, io_lvl);
    io_low = 1'h1;
    cyc(2);
    chk("card to host low", 2'h0, host_lvl);
    chk("host io out level", 2'h0, h_out);
    io_low = 1'h0;
    cyc(4);
    chk("card to host release", 2'h1, host_lvl);
  endtask : t_io

  task automatic t_presence;
    chk("status open default", 2'h0, status);
    sw = 1'h1;
    cyc(20);
    sw = 1'h0;
    cyc(1100);
    chk("spike rejected", 2'h0, status);
    sw = 1'h1;
    cyc(990);
    chk("status before filter", 2'h0, status);
    cyc(20);
    chk("status inserted", 2'h1, status);
    chk("present inserted", 2'h1, present);
    cfg.special_mode = 1'h1;
    cyc(3);
    chk("special low", 2'h0, status);
    cfg.special_mode = 1'h0;
    cfg.det_active_high = 1'h1;
    cyc(3);
    chk("active high not present", 2'h0, present);
    sw = 1'h0;
    cyc(1010);
    chk("active high status", 2'h1, status);
    cfg.special_mode = 1'h1;
    cyc(3);
    chk("special high", 2'h1, status);
  endtask : t_presence

  initial begin
    #(5 * 20000);
    n_errors++;
    test_done();
  end

  initial begin
    cyc(10);
    rst_n = 1'h1;
    cyc(1);
    chk("id after reset", 2'h3, id);
    chk("clock after reset", 2'h0, clk_out);
    chk("reset out after reset", 2'h0, rst_out);
    supply.on = 1'h1;
    supply.active = 1'h1;
    cyc(3);
    t_aux();
    t_clock();
    t_reset();
    t_io();
    t_presence();
    test_done();
  end
endmodule : testbench
`default_nettype wire
